// [hw/power_down_control_pkg.sv]
`default_nettype none

package power_down_control_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [31:0] PDC_ADDR = 32'hffff8614;
  localparam logic [7:0] PDC_RESET = 8'h1f;
  localparam int DEPTH_BIT = 7;
  localparam int FLOAT_BIT = 6;
  localparam int ZERO_BIT = 5;
  localparam logic [4:0] ONES_FIELD = 5'h1f;
  localparam logic DEPTH_RESET = PDC_RESET[DEPTH_BIT];
  localparam logic FLOAT_RESET = PDC_RESET[FLOAT_BIT];

  // ==========================================================
  // Clock restart after standby
  // ==========================================================
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESTART_NS = 100;
  // Least time, so round up
  localparam int RESTART_CYCLES = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef logic [2:0] restart_cnt_t;

  // ==========================================================
  // States and wake causes
  // ==========================================================
  typedef enum logic [1:0]
  {
    ST_RUN = 2'h0,
    ST_STANDBY = 2'h1,
    ST_RESTART = 2'h3,
    ST_SLEEP = 2'h2
  } pd_state_t;

  typedef enum logic [1:0]
  {
    CAUSE_NONE = 2'h0,
    CAUSE_IRQ = 2'h1,
    CAUSE_DMA = 2'h2,
    CAUSE_NMI = 2'h3
  } wake_cause_t;

endpackage : power_down_control_pkg

`default_nettype wire

// [hw/power_down_control.sv]
// Function
// R01: Sleep instruction with depth select 0 enters sleep: CPU halted, clock running.
// R02: Sleep instruction with depth select 1 enters standby: clock, CPU, peripherals stopped.
// R03: Control register, 8 bits, read/write, at 0xffff8614, any width, resets to 0x1f.
// R04: Bit 7 picks depth: 0 sleep, 1 standby; resets to 0.
// R05: Depth select cannot be set while watchdog runs; such write is ignored.
// R06: Software stops the watchdog before choosing standby depth.
// R07: Bit 6: 0 holds pins in standby, 1 floats port pins; resets to 0.
// R08: Port float bit cannot be set while watchdog runs.
// R09: Bit 5 reads 0, bits 4 to 0 read 1, whatever is written.
// R10: Software writes 0 to bit 5 and ones to bits 4 to 0.
// R11: CPU halts right after the sleep instruction, registers untouched.
// R12: Peripherals keep their clock during sleep.
// R13: An acceptable interrupt ends sleep, then interrupt exception processing.
// R14: Masked or disabled interrupts leave sleep in place.
// R15: Transfer controller address error ends sleep.
// R16: Power-on reset ends sleep.
// R17: Standby ends only on NMI or power-on reset.
// R18: After NMI in standby, clock restarts before the CPU resumes.
`timescale 1ns/1ps
`default_nettype none

module power_down_control
#(
  parameter int LEVEL_W = 4
)
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic watchdog_run_enable_i,
  input wire logic sleep_exec_i,
  input wire logic irq_req_i,
  input wire logic irq_src_enable_i,
  input wire logic [LEVEL_W-1:0] irq_level_i,
  input wire logic [LEVEL_W-1:0] status_mask_i,
  input wire logic dma_addr_err_i,
  input wire logic nmi_i,
  output logic cpu_halt_o,
  output logic clk_run_o,
  output logic periph_clk_en_o,
  output logic port_float_o,
  output logic wake_o,
  output logic [1:0] wake_cause_o,
  output logic [1:0] mode_o
);

  // ==========================================================
  // Bus slave
  // ==========================================================
  logic depth_ff;
  logic float_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic req;
  logic hit;
  logic wr_commit;
  logic [7:0] reg_view;

  assign req = wb_cyc_i && wb_stb_i;
  assign hit = wb_adr_i[31:2] == power_down_control_pkg::PDC_ADDR[31:2];
  // Write lands on the edge where the master samples ack
  assign wr_commit = req && ack_ff && wb_we_i && hit && wb_sel_i[0];

  assign reg_view = {depth_ff, float_ff, 1'b0, power_down_control_pkg::ONES_FIELD}; // [R09]

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= req && !ack_ff; // [R03]
    end
  end

  // Unmapped addresses answer with zero data
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_ff <= 32'h0;
    end
    else if (req && !ack_ff)
    begin
      rdata_ff <= hit ? {24'h0, reg_view} : 32'h0; // [R03]
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // ==========================================================
  // Control bits
  // ==========================================================
  // A one is refused while the watchdog runs; a zero always lands
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      depth_ff <= power_down_control_pkg::DEPTH_RESET; // [R04]
    end
    else if (wr_commit)
    begin
      if (!wb_dat_i[power_down_control_pkg::DEPTH_BIT])
      begin
        depth_ff <= 1'b0;
      end
      else if (!watchdog_run_enable_i)
      begin
        depth_ff <= 1'b1; // [R05]
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      float_ff <= power_down_control_pkg::FLOAT_RESET; // [R07]
    end
    else if (wr_commit)
    begin
      if (!wb_dat_i[power_down_control_pkg::FLOAT_BIT])
      begin
        float_ff <= 1'b0;
      end
      else if (!watchdog_run_enable_i)
      begin
        float_ff <= 1'b1; // [R08]
      end
    end
  end

  // ==========================================================
  // NMI pin synchroniser and edge
  // ==========================================================
  logic nmi_meta_ff;
  logic nmi_sync_ff;
  logic nmi_last_ff;
  logic nmi_edge;

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      nmi_meta_ff <= 1'b0;
      nmi_sync_ff <= 1'b0;
      nmi_last_ff <= 1'b0;
    end
    else
    begin
      nmi_meta_ff <= nmi_i;
      nmi_sync_ff <= nmi_meta_ff;
      nmi_last_ff <= nmi_sync_ff;
    end
  end

  assign nmi_edge = nmi_sync_ff && !nmi_last_ff;

  // ==========================================================
  // Power-down sequencer
  // ==========================================================
  power_down_control_pkg::pd_state_t state_ff;
  power_down_control_pkg::pd_state_t nxt_state;
  power_down_control_pkg::restart_cnt_t cnt_ff;
  power_down_control_pkg::wake_cause_t nxt_cause;
  logic irq_accept;

  // Priority must beat the mask, and the source must be enabled
  assign irq_accept = irq_req_i && irq_src_enable_i && (irq_level_i > status_mask_i); // [R14]

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cause = power_down_control_pkg::CAUSE_NONE;
    case (state_ff)
      power_down_control_pkg::ST_RUN:
      begin
        if (sleep_exec_i)
        begin
          if (depth_ff)
          begin
            nxt_state = power_down_control_pkg::ST_STANDBY; // [R02]
          end
          else
          begin
            nxt_state = power_down_control_pkg::ST_SLEEP; // [R01] [R11]
          end
        end
      end
      power_down_control_pkg::ST_SLEEP:
      begin
        if (nmi_edge)
        begin
          nxt_state = power_down_control_pkg::ST_RUN;
          nxt_cause = power_down_control_pkg::CAUSE_NMI;
        end
        else if (dma_addr_err_i)
        begin
          nxt_state = power_down_control_pkg::ST_RUN; // [R15]
          nxt_cause = power_down_control_pkg::CAUSE_DMA;
        end
        else if (irq_accept)
        begin
          nxt_state = power_down_control_pkg::ST_RUN; // [R13]
          nxt_cause = power_down_control_pkg::CAUSE_IRQ;
        end
      end
      power_down_control_pkg::ST_STANDBY:
      begin
        // Ordinary interrupts and bus errors are deaf here
        if (nmi_edge)
        begin
          nxt_state = power_down_control_pkg::ST_RESTART; // [R17]
        end
      end
      power_down_control_pkg::ST_RESTART:
      begin
        if (cnt_ff == power_down_control_pkg::restart_cnt_t'(0))
        begin
          nxt_state = power_down_control_pkg::ST_RUN; // [R18]
          nxt_cause = power_down_control_pkg::CAUSE_NMI;
        end
      end
      default:
      begin
        nxt_state = power_down_control_pkg::ST_RUN;
      end
    endcase
  end

  // Power-on reset drops any mode straight back to run
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_ff <= power_down_control_pkg::ST_RUN; // [R16]
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_ff <= power_down_control_pkg::restart_cnt_t'(0);
    end
    else if (nxt_state == power_down_control_pkg::ST_RESTART && state_ff != nxt_state)
    begin
      cnt_ff <= power_down_control_pkg::restart_cnt_t'(power_down_control_pkg::RESTART_CYCLES - 1); // [R18]
    end
    else if (cnt_ff != power_down_control_pkg::restart_cnt_t'(0))
    begin
      cnt_ff <= cnt_ff - power_down_control_pkg::restart_cnt_t'(1);
    end
  end

  // ==========================================================
  // Outputs, registered from the next state
  // ==========================================================
  logic halt_ff;
  logic clk_ff;
  logic float_out_ff;
  logic wake_ff;
  logic [1:0] cause_ff;

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      halt_ff <= 1'b0;
      clk_ff <= 1'b1;
      float_out_ff <= 1'b0;
    end
    else
    begin
      halt_ff <= nxt_state != power_down_control_pkg::ST_RUN; // [R11]
      clk_ff <= nxt_state != power_down_control_pkg::ST_STANDBY; // [R12] [R02] [R18]
      float_out_ff <= float_ff && nxt_state == power_down_control_pkg::ST_STANDBY; // [R07]
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wake_ff <= 1'b0;
      cause_ff <= power_down_control_pkg::CAUSE_NONE;
    end
    else
    begin
      wake_ff <= nxt_cause != power_down_control_pkg::CAUSE_NONE;
      if (nxt_cause != power_down_control_pkg::CAUSE_NONE)
      begin
        cause_ff <= nxt_cause;
      end
    end
  end

  assign cpu_halt_o = halt_ff;
  assign clk_run_o = clk_ff;
  assign periph_clk_en_o = clk_ff;
  assign port_float_o = float_out_ff;
  assign wake_o = wake_ff;
  assign wake_cause_o = cause_ff;
  assign mode_o = state_ff;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) // [R03]
    else $error("ack held longer than one cycle");

  read_reserved_a: assert property (wb_ack_o && !wb_we_i && hit
    |-> wb_dat_o[power_down_control_pkg::ZERO_BIT] == 1'b0 && wb_dat_o[4:0] == 5'h1f) // [R09]
    else $error("reserved bits read wrong");

  depth_guard_a: assert property ($rose(depth_ff) |-> $past(wr_commit) && !$past(watchdog_run_enable_i)) // [R05]
    else $error("depth select set while watchdog runs");

  float_guard_a: assert property ($rose(float_ff) |-> !$past(watchdog_run_enable_i)) // [R08]
    else $error("port float set while watchdog runs");

  sleep_entry_a: assert property (state_ff == power_down_control_pkg::ST_RUN && sleep_exec_i && !depth_ff
    |=> state_ff == power_down_control_pkg::ST_SLEEP && cpu_halt_o && clk_run_o) // [R01]
    else $error("sleep not entered");

  standby_entry_a: assert property (state_ff == power_down_control_pkg::ST_RUN && sleep_exec_i && depth_ff
    |=> cpu_halt_o && !clk_run_o && !periph_clk_en_o) // [R02]
    else $error("standby not entered");

  sleep_clock_a: assert property (state_ff == power_down_control_pkg::ST_SLEEP |-> periph_clk_en_o) // [R12]
    else $error("peripheral clock stopped in sleep");

  sleep_mask_a: assert property (state_ff == power_down_control_pkg::ST_SLEEP && !irq_accept
    && !dma_addr_err_i && !nmi_edge |=> state_ff == power_down_control_pkg::ST_SLEEP) // [R14]
    else $error("sleep left without cause");

  irq_wake_a: assert property (state_ff == power_down_control_pkg::ST_SLEEP && irq_accept
    && !dma_addr_err_i && !nmi_edge |=> !cpu_halt_o && wake_o && wake_cause_o == 2'h1) // [R13]
    else $error("interrupt did not end sleep");

  dma_wake_a: assert property (state_ff == power_down_control_pkg::ST_SLEEP && dma_addr_err_i && !nmi_edge
    |=> !cpu_halt_o && wake_cause_o == 2'h2) // [R15]
    else $error("address error did not end sleep");

  standby_hold_a: assert property (state_ff == power_down_control_pkg::ST_STANDBY && !nmi_edge
    |=> state_ff == power_down_control_pkg::ST_STANDBY && !clk_run_o) // [R17]
    else $error("standby left without nmi");

  restart_order_a: assert property (state_ff == power_down_control_pkg::ST_STANDBY && nmi_edge
    |=> (clk_run_o && cpu_halt_o) [*4] ##1 (!cpu_halt_o && wake_o)) // [R18]
    else $error("cpu resumed before clock restart");

  float_port_a: assert property (port_float_o |-> state_ff == power_down_control_pkg::ST_STANDBY && float_ff) // [R07]
    else $error("port floated outside standby");

endmodule : power_down_control

`default_nettype wire

// [tb/cpu_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// CPU core side
module cpu_core_model
(
  input wire logic sys_clk_i,
  input wire logic cpu_halt_i,
  input wire logic wake_i,
  output logic sleep_exec_o,
  output int wake_count_o
);
  initial sleep_exec_o = 1'b0;
  initial wake_count_o = 0;
  // A halted core cannot execute another sleep
  task automatic run_sleep();
    @(posedge sys_clk_i);
    if (!cpu_halt_i) sleep_exec_o <= 1'b1;
    @(posedge sys_clk_i);
    sleep_exec_o <= 1'b0;
    #1;
  endtask : run_sleep
  // Exception processing begins on each wake
  always @(posedge sys_clk_i)
    if (wake_i) wake_count_o <= wake_count_o + 1;
endmodule : cpu_core_model
`default_nettype wire

// [tb/power_down_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module power_down_control_bench;
  logic sys_clk_i, reset_n_i, cyc, stb, we, wdog, sleep_exec, irq, irq_en, dma_err, nmi, ack;
  logic halt, clk_run, pclk, pfloat, wake;
  logic [31:0] adr, wdat, rdat, rd;
  logic [3:0] sel, lvl, mask;
  logic [1:0] cause, mode;
  int err_count = 0;
  int comparisons = 0;
  int wakes, n;
  // ==========
  // Design and core
  power_down_control i_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .watchdog_run_enable_i(wdog), .sleep_exec_i(sleep_exec), .irq_req_i(irq), .irq_src_enable_i(irq_en),
    .irq_level_i(lvl), .status_mask_i(mask), .dma_addr_err_i(dma_err), .nmi_i(nmi), .cpu_halt_o(halt),
    .clk_run_o(clk_run), .periph_clk_en_o(pclk), .port_float_o(pfloat), .wake_o(wake),
    .wake_cause_o(cause), .mode_o(mode));
  cpu_core_model i_cpu (.sys_clk_i(sys_clk_i), .cpu_halt_i(halt), .wake_i(wake),
    .sleep_exec_o(sleep_exec), .wake_count_o(wakes));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  // ==========
  // Helpers
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask : tick
  // Waits for ack as long as it takes; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge sys_clk_i);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk_i);
  endtask : bus
  task automatic wait_wake();
    int k;
    k = 0;
    do
    begin
      tick(1);
      k++;
    end while (wake !== 1'b1 && k < 40);
  endtask : wait_wake
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // ==========
  // Scenarios
  task automatic t_reset();
    `CHK("mode", 2'h0, mode)
    `CHK("clk_run", 1'b1, clk_run)
    bus(1'b0, power_down_control_pkg::PDC_ADDR, 32'h0);
    `CHK("reg", 32'h1f, rd)
    $display("test reset done");
  endtask : t_reset
  task automatic t_guard();
    @(posedge sys_clk_i);
    wdog <= 1'b1;
    bus(1'b1, power_down_control_pkg::PDC_ADDR, 32'hff);
    bus(1'b0, power_down_control_pkg::PDC_ADDR, 32'h0);
    `CHK("guarded", 32'h1f, rd)
    bus(1'b1, power_down_control_pkg::PDC_ADDR + 32'h4, 32'h0);
    bus(1'b0, power_down_control_pkg::PDC_ADDR + 32'h4, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("test guard done");
  endtask : t_guard
  task automatic t_sleep();
    @(posedge sys_clk_i);
    wdog <= 1'b0;
    bus(1'b1, power_down_control_pkg::PDC_ADDR, 32'h1f);
    i_cpu.run_sleep();
    `CHK("mode", 2'h2, mode)
    `CHK("halt", 1'b1, halt)
    `CHK("pclk", 1'b1, pclk)
    // Level equal to mask is still masked
    irq <= 1'b1;
    irq_en <= 1'b1;
    lvl <= 4'h3;
    tick(5);
    `CHK("masked", 2'h2, mode)
    irq_en <= 1'b0;
    lvl <= 4'h5;
    tick(5);
    `CHK("disabled", 2'h2, mode)
    irq_en <= 1'b1;
    wait_wake();
    `CHK("cause", 2'h1, cause)
    // Core counts the wake on the edge after the pulse
    tick(1);
    `CHK("wakes", 1, wakes)
    irq <= 1'b0;
    i_cpu.run_sleep();
    dma_err <= 1'b1;
    wait_wake();
    dma_err <= 1'b0;
    `CHK("cause", 2'h2, cause)
    i_cpu.run_sleep();
    nmi <= 1'b1;
    wait_wake();
    nmi <= 1'b0;
    `CHK("nmi_cause", 2'h3, cause)
    `CHK("nmi_halt", 1'b0, halt)
    i_cpu.run_sleep();
    reset_n_i <= 1'b0;
    tick(2);
    `CHK("halt", 1'b0, halt)
    reset_n_i <= 1'b1;
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_standby();
    bus(1'b1, power_down_control_pkg::PDC_ADDR, 32'hdf);
    bus(1'b0, power_down_control_pkg::PDC_ADDR, 32'h0);
    `CHK("reg", 32'hdf, rd)
    i_cpu.run_sleep();
    `CHK("mode", 2'h1, mode)
    `CHK("clk_run", 1'b0, clk_run)
    `CHK("pfloat", 1'b1, pfloat)
    irq <= 1'b1;
    dma_err <= 1'b1;
    tick(6);
    `CHK("mode", 2'h1, mode)
    irq <= 1'b0;
    dma_err <= 1'b0;
    nmi <= 1'b1;
    n = 0;
    while (mode !== 2'h3 && n < 20)
    begin
      tick(1);
      n++;
    end
    `CHK("restart_clk", 1'b1, clk_run)
    `CHK("restart_halt", 1'b1, halt)
    n = 0;
    while (mode === 2'h3 && n < 20)
    begin
      tick(1);
      n++;
    end
    `CHK("restart_len", power_down_control_pkg::RESTART_CYCLES, n)
    `CHK("wake", 1'b1, wake)
    `CHK("cause", 2'h3, cause)
    nmi <= 1'b0;
    $display("test standby done");
  endtask : t_standby
  initial
  begin
    {reset_n_i, cyc, stb, we, wdog, irq, irq_en, dma_err, nmi} = '0;
    adr = 32'h0;
    wdat = 32'h0;
    sel = 4'hf;
    lvl = 4'h0;
    mask = 4'h3;
    repeat (4) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    tick(1);
    t_reset();
    t_guard();
    t_sleep();
    t_standby();
    complete_run();
  end
  // Whole run needs about eighty cycles
  initial
  begin
    #50000;
    err_count++;
    complete_run();
  end
endmodule : power_down_control_bench
`default_nettype wire
